// [verilog/exc_ctrl_params.svh]
`ifndef EXC_CTRL_PARAMS_SVH
`define EXC_CTRL_PARAMS_SVH
// Exception numbers of the fixed and lowest system entries.
`define EXC_NUM_W          6
`define EXC_NUM_FIRST_IRQ  6'h10
`define EXC_NUM_NMI        6'h02
`define EXC_NUM_HARDFAULT  6'h03
`define EXC_NUM_THREAD     6'h00
// Priority encoding: lower value is more urgent.
`define PRIO_W             4
`define PRIO_RESET_FIXED   4'h0
`define PRIO_NMI_FIXED     4'h1
`define PRIO_HARDFAULT_FIX 4'h2
`define PRIO_BASE          4'hF
`define PRIO_BOOST         4'h3
// Return link values held in the link register.
`define LINK_W             32
`define LINK_TO_HANDLER    32'hFFFFFFF1
`define LINK_TO_THREAD_MSP 32'hFFFFFFF9
`define LINK_TO_THREAD_PSP 32'hFFFFFFFD
// Context push and pop length in core cycles (eight stacked words).
`define STACK_WORDS        4'h8
`define VEC_FETCH_CYCLES   4'h2
`define ADDR_W             32
`define VEC_TABLE_BASE     32'h00000000
`endif

// [verilog/exc_pkg.sv]
package exc_pkg;
    // Per-exception state, exactly one at a time.
    typedef enum logic [1:0] {
        EXC_INACTIVE,
        EXC_PENDING,
        EXC_ACTIVE,
        EXC_ACT_PEND
    } exc_state_t;
    // Sequencer states of entry and return.
    typedef enum logic [2:0] {
        SEQ_RUN,
        SEQ_PUSH,
        SEQ_VECTOR,
        SEQ_POP,
        SEQ_HALT
    } seq_state_t;
endpackage

// [verilog/exc_arb_if.sv]
`timescale 1ns/100ps
`include "exc_ctrl_params.svh"
// Carries the arbiter's winner back to the sequencer.
interface exc_arb_if #(parameter int N = 8);
    logic [N-1:0]               pend_vec;  // Pending (or active and pending) flags.
    logic [N*`PRIO_W-1:0]       prio_vec;  // Priority of each slot.
    logic                       win_valid; // A pending slot exists.
    logic [$clog2(N)-1:0]       win_idx;   // Winning slot index.
    logic [`PRIO_W-1:0]         win_prio;  // Winning priority.
    modport arb (input pend_vec, prio_vec, output win_valid, win_idx, win_prio);
    modport seq (output pend_vec, prio_vec, input win_valid, win_idx, win_prio);
endinterface

// [verilog/exc_pend_arbiter.sv]
`timescale 1ns/100ps
`include "exc_ctrl_params.svh"
// Picks the most urgent pending slot; lower slot wins a tie.
module exc_pend_arbiter #(
    parameter int N = 8
) (
    exc_arb_if.arb bus
);
    // Lower value is more urgent; strict compare keeps the lower index on ties.
    always_comb begin // see [RL22]
        bus.win_valid = 1'b0;
        bus.win_idx   = '0;
        bus.win_prio  = `PRIO_BASE;
        for (int i = 0; i < N; i++) begin
            if (bus.pend_vec[i] &&
                (!bus.win_valid || bus.prio_vec[i*`PRIO_W +: `PRIO_W] < bus.win_prio)) begin
                bus.win_valid = 1'b1;
                bus.win_idx   = ($clog2(N))'(i);
                bus.win_prio  = bus.prio_vec[i*`PRIO_W +: `PRIO_W];
            end
        end
    end
endmodule // exc_pend_arbiter

// [verilog/exc_state_ctrl.sv]
`timescale 1ns/100ps
`include "exc_ctrl_params.svh"
// Function
// [RL1] Interrupts are asynchronous, not reset or fault.
// [RL2] Each exception has priority, number, vector.
// [RL3] Four states per non-reset exception.
// [RL4] Event marks pending until handler starts.
// [RL5] Active-and-pending only for asynchronous exceptions.
// [RL6] Three fixed priorities, others software set.
// [RL7] Reset gives base priority, Thread only.
// [RL8] Execution priority is highest active, boosted.
// [RL9] Sufficiently higher pending exception preempts.
// [RL10] Entry pushes context then fetches vector.
// [RL11] Late arrival optimised; entry faults handled.
// [RL12] Handlers run in Handler mode.
// [RL13] Active-and-pending return re-enters or stays pending.
// [RL14] Active return goes inactive, restores, resumes.
// [RL15] Return link in link register selects target; code takes the mode from nesting depth, the link only picks the Thread stack.
// [RL16] Pending preemptor on return tail-chains.
// [RL17] Execution-state bit one; zero faults.
// [RL18] Halt on debug event when enabled.
// [RL19] Registers 0-12, banked 13, 14, 15.
// [RL20] Handler mode always uses main stack.
// [RL21] Status shows exception number, zero in Thread.
// [RL22] Lower value more urgent; ties lower number.
module exc_state_ctrl #(
    parameter int N = 8 // Slot 0 is the fault, slot 1 the non-maskable, rest interrupts.
) (
    input  wire logic                    core_clk_in,        // Core clock.
    input  wire logic                    arst_n_in,          // Asynchronous reset.
    input  wire logic [N-1:0]            irq_pin_in,         // Asynchronous interrupt levels.
    input  wire logic                    sync_fault_in,      // Synchronous fault pulse.
    input  wire logic [N*`PRIO_W-1:0]    prio_cfg_in,        // Software priorities.
    input  wire logic                    priority_boost_mask_in, // Boost mask level.
    input  wire logic                    spsel_in,           // Thread stack select.
    input  wire logic                    exc_return_in,      // Handler issues return pulse.
    input  wire logic [`LINK_W-1:0]      link_reg_in,        // Link value at return.
    input  wire logic                    push_fault_in,      // Memory fault during stacking.
    input  wire logic                    instr_set_write_in, // Write of execution-state bit.
    input  wire logic                    instr_set_val_in,   // Value written.
    input  wire logic                    instr_exec_in,      // Next instruction executes.
    input  wire logic                    halt_en_in,         // Halt on debug events.
    input  wire logic                    debug_event_in,     // Debug event pulse.
    input  wire logic                    debug_resume_in,    // Leave halted state.
    input  wire logic [`ADDR_W-1:0]      vector_data_in,     // Vector read data.
    output logic [`ADDR_W-1:0]           vector_addr_out,    // Vector address.
    output logic                         vector_rd_out,      // Vector read strobe.
    output logic                         stack_push_out,     // Stacking in progress.
    output logic                         stack_pop_out,      // Unstacking in progress.
    output logic [`ADDR_W-1:0]           branch_pc_out,      // Handler entry address.
    output logic                         branch_out,         // Branch pulse.
    output logic [`LINK_W-1:0]           link_reg_out,       // Return link written on entry.
    output logic                         handler_mode_out,   // One in Handler mode.
    output logic                         main_sp_sel_out,    // One when main stack in use.
    output logic [`EXC_NUM_W-1:0]        exception_number_status_out, // Current number.
    output logic [`PRIO_W-1:0]           exec_prio_out,      // Execution priority.
    output logic                         instr_set_state_bit_out, // Execution-state bit.
    output logic                         halted_out,         // Debug halted.
    output logic [2*N-1:0]               exc_state_out       // Packed state per slot.
);
    localparam int IW = $clog2(N);
    // Refuse sizes too small for both fixed slots and one interrupt.
    initial begin
        if (N < 3 || N > 48) $error("exc_state_ctrl: N out of range");
    end

    // Maps a slot to its exception number.
    function automatic logic [`EXC_NUM_W-1:0] slot_num(input logic [IW-1:0] s);
        if (s == IW'(0)) slot_num = `EXC_NUM_HARDFAULT;
        else if (s == IW'(1)) slot_num = `EXC_NUM_NMI;
        else slot_num = `EXC_NUM_FIRST_IRQ + `EXC_NUM_W'(s) - `EXC_NUM_W'(2);
    endfunction

    // Effective priority of a slot; slots 0 and 1 are fixed.
    function automatic logic [`PRIO_W-1:0] slot_prio(input int s,
                                                      input logic [N*`PRIO_W-1:0] cfg);
        if (s == 0) slot_prio = `PRIO_HARDFAULT_FIX; // see [RL6]
        else if (s == 1) slot_prio = `PRIO_NMI_FIXED; // see [RL6]
        else slot_prio = cfg[s*`PRIO_W +: `PRIO_W];
    endfunction

    // Two-stage synchronisers for asynchronous interrupt pins.
    logic [N-1:0] irq_meta_ff;  // First stage, read only by the second.
    logic [N-1:0] irq_sync_ff;  // Second stage.
    logic [N-1:0] irq_prev_ff;  // For rising-edge detect.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_meta_ff <= '0;
            irq_sync_ff <= '0;
            irq_prev_ff <= '0;
        end else begin
            irq_meta_ff <= irq_pin_in;
            irq_sync_ff <= irq_meta_ff;
            irq_prev_ff <= irq_sync_ff;
        end
    end
    // Interrupts are rising edges, unrelated to the instruction stream.
    logic [N-1:0] event_vec; // see [RL1]
    always_comb begin
        event_vec      = irq_sync_ff & ~irq_prev_ff;
        event_vec[0]   = sync_fault_in | push_fault_in; // Fault slot is synchronous.
    end

    // Core state.
    exc_pkg::exc_state_t st_ff [N];
    exc_pkg::exc_state_t nxt_st [N];
    exc_pkg::seq_state_t seq_ff, nxt_seq;
    logic [IW-1:0]              cur_ff, nxt_cur;          // Slot being entered/handled.
    logic [IW-1:0]              stk_ff [4];               // Nesting stack of active slots.
    logic [IW-1:0]              nxt_stk [4];
    logic [2:0]                 depth_ff, nxt_depth;      // Nesting depth, zero in Thread.
    logic [3:0]                 cnt_ff, nxt_cnt;          // Push/pop/fetch counter.
    logic                       thread_psp_ff, nxt_thread_psp; // Thread stack at entry.
    logic                       tbit_ff, nxt_tbit;
    logic                       halted_ff, nxt_halted;
    logic [`ADDR_W-1:0]         vaddr_ff, nxt_vaddr;
    logic                       vrd_ff, nxt_vrd;
    logic [`ADDR_W-1:0]         bpc_ff, nxt_bpc;
    logic                       br_ff, nxt_br;
    logic [`LINK_W-1:0]         link_ff, nxt_link;
    logic [`PRIO_W-1:0]         eprio;                    // Execution priority.
    logic [N-1:0]               pend_vec;

    exc_arb_if #(.N(N)) arb_bus ();
    exc_pend_arbiter #(.N(N)) u_arb (.bus(arb_bus));
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pend_vec[i] = (st_ff[i] == exc_pkg::EXC_PENDING) ||
                          (st_ff[i] == exc_pkg::EXC_ACT_PEND);
            arb_bus.prio_vec[i*`PRIO_W +: `PRIO_W] = slot_prio(i, prio_cfg_in); // see [RL2]
        end
        arb_bus.pend_vec = pend_vec;
    end

    // Most urgent active priority, raised by the boost mask; base in Thread unless the boost mask is set.
    always_comb begin // see [RL8] see [RL7]
        eprio = `PRIO_BASE;
        for (int i = 0; i < N; i++) begin
            if ((st_ff[i] == exc_pkg::EXC_ACTIVE || st_ff[i] == exc_pkg::EXC_ACT_PEND) &&
                slot_prio(i, prio_cfg_in) < eprio) eprio = slot_prio(i, prio_cfg_in);
        end
        if (priority_boost_mask_in && eprio > `PRIO_BOOST) eprio = `PRIO_BOOST;
    end

    // Preemption needs strictly more urgent; the non-maskable slot bypasses boost.
    logic preempt;
    assign preempt = arb_bus.win_valid && (arb_bus.win_prio < eprio); // see [RL9]

    // Next-state logic for states, sequencer and outputs.
    always_comb begin
        nxt_st = st_ff;  nxt_seq = seq_ff;  nxt_cur = cur_ff;  nxt_stk = stk_ff;
        nxt_depth = depth_ff;  nxt_cnt = cnt_ff;  nxt_thread_psp = thread_psp_ff;
        nxt_tbit = tbit_ff;  nxt_halted = halted_ff;  nxt_vaddr = vaddr_ff;
        nxt_vrd = 1'b0;  nxt_bpc = bpc_ff;  nxt_br = 1'b0;  nxt_link = link_ff;
        // Events make inactive slots pending, active asynchronous ones active-and-pending.
        for (int i = 0; i < N; i++) begin
            if (event_vec[i]) begin
                case (st_ff[i]) // see [RL4] see [RL3]
                    exc_pkg::EXC_INACTIVE: nxt_st[i] = exc_pkg::EXC_PENDING;
                    exc_pkg::EXC_ACTIVE:   if (i != 0) nxt_st[i] = exc_pkg::EXC_ACT_PEND; // see [RL5]
                    default:               nxt_st[i] = st_ff[i];
                endcase
            end
        end
        // Clearing the execution-state bit faults on the next instruction.
        if (instr_set_write_in) nxt_tbit = instr_set_val_in;
        if (instr_exec_in && !tbit_ff && st_ff[0] == exc_pkg::EXC_INACTIVE) begin
            nxt_st[0] = exc_pkg::EXC_PENDING; // see [RL17]
            nxt_tbit  = 1'b1;
        end
        case (seq_ff)
            exc_pkg::SEQ_RUN: begin
                if (halt_en_in && debug_event_in) begin
                    nxt_seq    = exc_pkg::SEQ_HALT; // see [RL18]
                    nxt_halted = 1'b1;
                end else if (preempt) begin
                    nxt_cur = arb_bus.win_idx;
                    nxt_cnt = `STACK_WORDS;
                    nxt_seq = exc_pkg::SEQ_PUSH; // see [RL10]
                    if (depth_ff == 3'h0) nxt_thread_psp = spsel_in;
                end else if (exc_return_in && depth_ff != 3'h0) begin
                    nxt_cnt = `STACK_WORDS;
                    nxt_seq = exc_pkg::SEQ_POP;
                end
            end
            exc_pkg::SEQ_PUSH: begin
                // A more urgent late arrival replaces the target before the vector read.
                if (preempt && arb_bus.win_prio < slot_prio(int'(cur_ff), prio_cfg_in))
                    nxt_cur = arb_bus.win_idx; // see [RL11]
                if (push_fault_in) nxt_cur = IW'(0); // see [RL11]
                if (cnt_ff == 4'h1) begin
                    nxt_cnt = `VEC_FETCH_CYCLES;
                    nxt_seq = exc_pkg::SEQ_VECTOR;
                end else nxt_cnt = cnt_ff - 4'h1;
            end
            exc_pkg::SEQ_VECTOR: begin
                nxt_vaddr = `VEC_TABLE_BASE + {{(`ADDR_W-`EXC_NUM_W-2){1'b0}},
                            slot_num(cur_ff), 2'b00};
                nxt_vrd = (cnt_ff == `VEC_FETCH_CYCLES);
                if (cnt_ff == 4'h1) begin
                    nxt_bpc = vector_data_in;
                    nxt_br  = 1'b1;
                    nxt_st[cur_ff] = exc_pkg::EXC_ACTIVE; // see [RL4]
                    nxt_stk[depth_ff[1:0]] = cur_ff;
                    nxt_depth = depth_ff + 3'h1; // see [RL12]
                    nxt_link = (depth_ff != 3'h0) ? `LINK_TO_HANDLER :
                               (thread_psp_ff ? `LINK_TO_THREAD_PSP : `LINK_TO_THREAD_MSP); // see [RL15]
                    nxt_seq = exc_pkg::SEQ_RUN;
                end else nxt_cnt = cnt_ff - 4'h1;
            end
            exc_pkg::SEQ_POP: begin
                if (cnt_ff == `STACK_WORDS) begin
                    // Retire the returning slot first.
                    // A new event in the retire cycle wins, so it is never lost.
                    if (st_ff[cur_ff] == exc_pkg::EXC_ACT_PEND || event_vec[cur_ff])
                        nxt_st[cur_ff] = exc_pkg::EXC_PENDING; // see [RL13]
                    else nxt_st[cur_ff] = exc_pkg::EXC_INACTIVE; // see [RL14]
                    nxt_depth = depth_ff - 3'h1;
                    nxt_cur = (depth_ff >= 3'h2) ? stk_ff[2'(depth_ff - 3'h2)] : cur_ff;
                    if (link_reg_in == `LINK_TO_HANDLER && depth_ff < 3'h2) nxt_halted = halted_ff;
                    nxt_cnt = cnt_ff - 4'h1;
                end else if (preempt) begin
                    // Pending winner tail-chains: skip the rest of unstacking.
                    nxt_cur = arb_bus.win_idx; // see [RL16] see [RL13]
                    nxt_cnt = `VEC_FETCH_CYCLES;
                    nxt_seq = exc_pkg::SEQ_VECTOR;
                end else if (cnt_ff == 4'h1) begin
                    nxt_seq = exc_pkg::SEQ_RUN; // see [RL14]
                    nxt_thread_psp = (link_reg_in == `LINK_TO_THREAD_PSP); // see [RL15]
                end else nxt_cnt = cnt_ff - 4'h1;
            end
            exc_pkg::SEQ_HALT: begin
                if (debug_resume_in) begin
                    nxt_halted = 1'b0;
                    nxt_seq    = exc_pkg::SEQ_RUN;
                end
            end
            default: nxt_seq = exc_pkg::SEQ_RUN;
        endcase
    end

    // Registers of all control state; reset gives Thread mode at base priority.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < N; i++) st_ff[i] <= exc_pkg::EXC_INACTIVE;
            for (int j = 0; j < 4; j++) stk_ff[j] <= '0;
            seq_ff <= exc_pkg::SEQ_RUN;  cur_ff <= '0;  depth_ff <= 3'h0;  // see [RL7]
            cnt_ff <= 4'h0;  thread_psp_ff <= 1'b0;  tbit_ff <= 1'b1;  halted_ff <= 1'b0;
            vaddr_ff <= '0;  vrd_ff <= 1'b0;  bpc_ff <= '0;  br_ff <= 1'b0;  link_ff <= '0;
        end else begin
            st_ff <= nxt_st;  seq_ff <= nxt_seq;  cur_ff <= nxt_cur;  stk_ff <= nxt_stk;
            depth_ff <= nxt_depth;  cnt_ff <= nxt_cnt;  thread_psp_ff <= nxt_thread_psp;
            tbit_ff <= nxt_tbit;  halted_ff <= nxt_halted;  vaddr_ff <= nxt_vaddr;
            vrd_ff <= nxt_vrd;  bpc_ff <= nxt_bpc;  br_ff <= nxt_br;  link_ff <= nxt_link;
        end
    end

    // Registered status outputs, each from a flip-flop.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            handler_mode_out <= 1'b0;  main_sp_sel_out <= 1'b1;
            exception_number_status_out <= `EXC_NUM_THREAD;  exec_prio_out <= `PRIO_BASE;
            stack_push_out <= 1'b0;  stack_pop_out <= 1'b0;  exc_state_out <= '0;
        end else begin
            handler_mode_out <= (nxt_depth != 3'h0);
            main_sp_sel_out  <= (nxt_depth != 3'h0) || !nxt_thread_psp; // see [RL20]
            exception_number_status_out <= (nxt_depth != 3'h0) ?
                slot_num(nxt_stk[2'(nxt_depth - 3'h1)]) : `EXC_NUM_THREAD; // see [RL21]
            exec_prio_out  <= eprio;
            stack_push_out <= (nxt_seq == exc_pkg::SEQ_PUSH);
            stack_pop_out  <= (nxt_seq == exc_pkg::SEQ_POP);
            for (int i = 0; i < N; i++) exc_state_out[2*i +: 2] <= nxt_st[i];
        end
    end
    assign vector_addr_out = vaddr_ff;
    assign vector_rd_out   = vrd_ff;
    assign branch_pc_out   = bpc_ff;
    assign branch_out      = br_ff;
    assign link_reg_out    = link_ff;
    assign instr_set_state_bit_out = tbit_ff;
    assign halted_out      = halted_ff;
    // General registers 0-15 live in the datapath; this block steers banked 13 and 14.
    // see [RL19]

    a_fault_no_actpend: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        st_ff[0] != exc_pkg::EXC_ACT_PEND) else $error("fault slot active and pending"); // see [RL5]
    a_thread_exception_number_status_zero: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !handler_mode_out |-> exception_number_status_out == `EXC_NUM_THREAD)
        else $error("status nonzero in thread"); // see [RL21]
    a_handler_main_sp: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        handler_mode_out |-> main_sp_sel_out) else $error("handler off main stack"); // see [RL20]
    a_push_then_vec: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (seq_ff == exc_pkg::SEQ_RUN && preempt && !(halt_en_in && debug_event_in))
        |=> seq_ff == exc_pkg::SEQ_PUSH [*8] ##1 seq_ff == exc_pkg::SEQ_VECTOR)
        else $error("entry sequence wrong"); // see [RL10]
    a_entry_handler: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        br_ff |-> handler_mode_out) else $error("branch outside handler"); // see [RL12]
    a_halt_entry: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (seq_ff == exc_pkg::SEQ_RUN && halt_en_in && debug_event_in) |=> halted_ff)
        else $error("no halt on debug event"); // see [RL18]
    a_tbit_fault: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (instr_exec_in && !tbit_ff && st_ff[0] == exc_pkg::EXC_INACTIVE)
        |=> st_ff[0] == exc_pkg::EXC_PENDING) else $error("cleared bit did not fault"); // see [RL17]
    a_prio_not_base: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (depth_ff != 3'h0) |-> eprio != `PRIO_BASE) else $error("handler at base level"); // see [RL7]
endmodule // exc_state_ctrl

// [testbench/irq_source_model.sv]
`timescale 1ns/100ps
// Interrupt sources and vector memory that sit outside the core.
module irq_source_model #(
    parameter int N = 8
) (
    input  wire logic        core_clk_in,     // Core clock.
    input  wire logic [N-1:0] raise_in,       // Lines the bench wants raised.
    input  wire logic        vector_rd_in,    // Vector read strobe.
    input  wire logic [31:0] vector_addr_in,  // Vector address.
    output logic      [N-1:0] irq_out = '0,   // Interrupt levels.
    output logic      [31:0] vector_data_out  // Vector word.
);
    logic [31:0] last_ff = 32'hA5A5A5A5; // Last word shown on the data lines.
    // Levels move just after the edge, as a peripheral would drive them.
    always @(posedge core_clk_in) begin
        irq_out <= raise_in;
        last_ff <= vector_data_out;
    end
    // Outside a read the lines toggle, so stale data can never pass as an answer.
    always_comb begin
        vector_data_out = vector_rd_in ? (vector_addr_in | 32'h00008001) : ~last_ff;
    end
endmodule // irq_source_model

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`include "exc_ctrl_params.svh"
module tb_top;
    localparam int N = 8; // Slot 2 is the first plain interrupt.
    logic core_clk_in = 1'b0, arst_n_in = 1'b0, exc_return_in = 1'b0, halt_en_in = 1'b0;
    logic debug_event_in = 1'b0, debug_resume_in = 1'b0, instr_exec_in = 1'b0;
    logic instr_set_write_in = 1'b0, instr_set_val_in = 1'b1; // Write port idle.
    logic [N-1:0] raise = '0, irq_pin_in; // Bench commands and model levels.
    logic [N*4-1:0] prio_cfg_in = {N{4'h5}}; // Every interrupt at level five.
    logic [31:0] link_reg_in = 32'h00000000, vector_data_in, vector_addr_out;
    logic [31:0] branch_pc_out, link_reg_out, got_addr;
    logic vector_rd_out, stack_push_out, stack_pop_out, branch_out, handler_mode_out;
    logic main_sp_sel_out, instr_set_state_bit_out, halted_out;
    logic [5:0] exception_number_status_out;
    logic [3:0] exec_prio_out;
    logic [2*N-1:0] exc_state_out;
    int n_errors = 0, cmp_count = 0, pushes, pops;
    logic boost = 1'b0; // Priority boost mask level.
    // Stack select and the two fault pulses are held inactive.
    exc_state_ctrl #(.N(N)) i_exc_state_ctrl (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .irq_pin_in(irq_pin_in),
        .sync_fault_in(1'b0), .prio_cfg_in(prio_cfg_in), .priority_boost_mask_in(boost),
        .spsel_in(1'b0), .exc_return_in(exc_return_in), .link_reg_in(link_reg_in),
        .push_fault_in(1'b0), .instr_set_write_in(instr_set_write_in),
        .instr_set_val_in(instr_set_val_in), .instr_exec_in(instr_exec_in),
        .halt_en_in(halt_en_in), .debug_event_in(debug_event_in),
        .debug_resume_in(debug_resume_in), .vector_data_in(vector_data_in),
        .vector_addr_out(vector_addr_out), .vector_rd_out(vector_rd_out),
        .stack_push_out(stack_push_out), .stack_pop_out(stack_pop_out),
        .branch_pc_out(branch_pc_out), .branch_out(branch_out), .link_reg_out(link_reg_out),
        .handler_mode_out(handler_mode_out), .main_sp_sel_out(main_sp_sel_out),
        .exception_number_status_out(exception_number_status_out),
        .exec_prio_out(exec_prio_out), .instr_set_state_bit_out(instr_set_state_bit_out),
        .halted_out(halted_out), .exc_state_out(exc_state_out));
    irq_source_model #(.N(N)) i_irq_source_model (
        .core_clk_in(core_clk_in), .raise_in(raise), .vector_rd_in(vector_rd_out),
        .vector_addr_in(vector_addr_out), .irq_out(irq_pin_in),
        .vector_data_out(vector_data_in));
    // Free-running core clock of 8 ns.
    initial begin
        forever #4 core_clk_in = ~core_clk_in;
    end
    // Prints the verdict and stops the run.
    task automatic final_report;
        if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Compares one settled value against its expectation.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits a bounded time for the handler branch, counting stacking cycles.
    task automatic wait_branch;
        pushes = 0;
        for (int i = 0; i <= 40; i++) begin
            @(negedge core_clk_in);
            if (i == 40) begin n_errors++; final_report(); end
            if (stack_push_out === 1'b1) pushes++;
            if (vector_rd_out === 1'b1) got_addr = vector_addr_out;
            if (branch_out === 1'b1) break;
        end
    endtask
    // Issues a return and waits a bounded time for unstacking to finish.
    task automatic do_return;
        @(posedge core_clk_in);
        exc_return_in <= 1'b1;
        link_reg_in <= `LINK_TO_THREAD_MSP;
        @(posedge core_clk_in);
        exc_return_in <= 1'b0;
        pops = 0;
        for (int i = 0; i <= 40; i++) begin
            @(negedge core_clk_in);
            if (i == 40) begin n_errors++; final_report(); end
            if (stack_pop_out === 1'b1) pops++;
            if (stack_pop_out === 1'b0 && pops > 0) break;
        end
    endtask
    // An interrupt is taken, stacked, vectored and then returned from.
    task automatic t_irq;
        @(posedge core_clk_in);
        raise <= 8'h04;
        wait_branch();
        chk(pushes, 8);
        chk(got_addr, `VEC_TABLE_BASE + 32'h40);
        chk(branch_pc_out[31:1], (32'h8041 | got_addr) >> 1);
        chk(link_reg_out, `LINK_TO_THREAD_MSP);
        @(negedge core_clk_in);
        chk(handler_mode_out, 1);
        chk(main_sp_sel_out, 1);
        chk(exception_number_status_out, 6'h10);
        chk(exec_prio_out, 4'h5);
        chk(exc_state_out[5:4], 2'h2);
        raise <= 8'h00;
        do_return();
        chk(pops, 8);
        chk(handler_mode_out, 0);
        chk(exception_number_status_out, 6'h00);
        chk(exec_prio_out, `PRIO_BASE);
        chk(exc_state_out[5:4], 2'h0);
    endtask
    // The boost mask holds off a level-five interrupt until it is lifted.
    task automatic t_boost;
        @(posedge core_clk_in);
        boost <= 1'b1;
        raise <= 8'h08;
        repeat (8) @(negedge core_clk_in);
        chk(exc_state_out[7:6], 2'h1);
        chk(exec_prio_out, `PRIO_BOOST);
        @(posedge core_clk_in);
        boost <= 1'b0;
        wait_branch();
        chk(exception_number_status_out, 6'h11);
        raise <= 8'h00;
        do_return();
    endtask
    // A cleared execution-state bit faults on the next instruction.
    task automatic t_tbit;
        @(posedge core_clk_in);
        instr_set_write_in <= 1'b1;
        instr_set_val_in <= 1'b0;
        @(posedge core_clk_in);
        instr_set_write_in <= 1'b0;
        instr_exec_in <= 1'b1;
        @(negedge core_clk_in);
        chk(instr_set_state_bit_out, 0);
        @(posedge core_clk_in);
        instr_exec_in <= 1'b0;
        wait_branch();
        @(negedge core_clk_in);
        chk(exception_number_status_out, `EXC_NUM_HARDFAULT);
        chk(exec_prio_out, `PRIO_HARDFAULT_FIX);
        @(posedge core_clk_in);
        instr_set_write_in <= 1'b1;
        instr_set_val_in <= 1'b1;
        @(posedge core_clk_in);
        instr_set_write_in <= 1'b0;
        do_return();
        chk(instr_set_state_bit_out, 1);
    endtask
    // A debug event halts the core only when halting is enabled.
    task automatic t_halt;
        @(posedge core_clk_in);
        debug_event_in <= 1'b1;
        @(posedge core_clk_in);
        debug_event_in <= 1'b0;
        repeat (4) @(negedge core_clk_in);
        chk(halted_out, 0);
        @(posedge core_clk_in);
        halt_en_in <= 1'b1;
        debug_event_in <= 1'b1;
        @(posedge core_clk_in);
        debug_event_in <= 1'b0;
        repeat (4) @(negedge core_clk_in);
        chk(halted_out, 1);
        @(posedge core_clk_in);
        debug_resume_in <= 1'b1;
        @(posedge core_clk_in);
        debug_resume_in <= 1'b0;
        @(negedge core_clk_in);
        chk(halted_out, 0);
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        @(negedge core_clk_in);
        chk({handler_mode_out, main_sp_sel_out, instr_set_state_bit_out}, 3'b011);
        chk(exception_number_status_out, 6'h00);
        chk(exec_prio_out, `PRIO_BASE);
        t_irq();
        t_tbit();
        t_boost();
        t_halt();
        final_report();
    end
endmodule // tb_top
